// [design/tseh_core.v]
// Operating state and detected error handling for the process and protection task groups.
`timescale 1ns/100ps
`include "tseh_regs.vh"
module tseh_core #(
  parameter TICK_CYCLES = `TSEH_TICK_CYCLES
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Commands and configuration
  input  wire        runCmd,
  input  wire        stopCmd,
  input  wire        autoStart,
  input  wire        appValid,
  input  wire        maintMode,
  input  wire        safeHoldSel,
  // Watchdog limits in milliseconds
  input  wire [15:0] wdLimitTop,
  input  wire [15:0] wdLimitSafe,
  input  wire [15:0] wdLimitMain,
  input  wire [15:0] wdLimitBg0,
  input  wire [15:0] wdLimitBg1,
  // Task scheduling
  input  wire [4:0]  taskReq,
  input  wire [4:0]  taskActive,
  output reg  [4:0]  taskGrant,
  // Dual execution results of the protection task
  input  wire        safeResultValid,
  input  wire [31:0] safeResultA,
  input  wire [31:0] safeResultB,
  // Fault inputs from logic
  input  wire        internalErr,
  // Pins from outside the clock domain
  input  wire        powerDownPin,
  input  wire        powerOkPin,
  input  wire        reserveFullPin,
  input  wire        fwLoadMainPin,
  input  wire        fwLoadCoprocPin,
  // Per-task control
  output wire [4:0]  inSample,
  output wire [4:0]  execEn,
  output wire [4:0]  outUpdate,
  output wire [4:0]  outFallback,
  output wire        safeOutHold,
  output wire        safeOutFallback,
  // Status
  output reg  [1:0]  procState,
  output reg  [1:0]  safeState,
  output reg  [2:0]  pacState,
  output reg  [2:0]  statusMsg,
  output reg         safetyTrip,
  output reg         saveData,
  output reg         logValid,
  output reg  [1:0]  logCode
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [4:0] pinMeta_reg;
  reg  [4:0] pinSync_reg;
  wire       powerDown;
  wire       powerBack;
  wire       fwLoad;

  always @(posedge sys_clk) begin
    if (rst) begin
      pinMeta_reg <= 5'h00;
      pinSync_reg <= 5'h00;
    end else begin
      pinMeta_reg <= {fwLoadCoprocPin, fwLoadMainPin, reserveFullPin, powerOkPin, powerDownPin};
      pinSync_reg <= pinMeta_reg;
    end
  end

  assign powerDown = pinSync_reg[0];
  assign powerBack = pinSync_reg[1] & pinSync_reg[2];
  assign fwLoad    = pinSync_reg[3] | pinSync_reg[4];

  // ----------------------------------------------------------------
  // Millisecond tick divider
  // ----------------------------------------------------------------
  reg  [23:0] tickCnt_reg;
  wire        tick;

  assign tick = (tickCnt_reg == TICK_CYCLES[23:0] - 24'h000001);

  always @(posedge sys_clk) begin
    if (rst || tick) begin
      tickCnt_reg <= 24'h000000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Fixed priority arbiter
  // ----------------------------------------------------------------
  wire procRunning;
  wire safeRunning;
  wire [4:0] runMask;

  assign procRunning = (pacState == `TSEH_PAC_NORMAL) && (procState == `TSEH_GRP_RUN);
  assign safeRunning = (pacState == `TSEH_PAC_NORMAL) && (safeState == `TSEH_GRP_RUN);
  assign runMask     = {procRunning, procRunning, procRunning, safeRunning, procRunning};

  always @* begin
    taskGrant = 5'h00;
    if (taskReq[0] && runMask[0]) begin
      taskGrant = 5'h01;
    end else if (taskReq[1] && runMask[1]) begin
      taskGrant = 5'h02;
    end else if (taskReq[2] && runMask[2]) begin
      taskGrant = 5'h04;
    end else if (taskReq[3] && runMask[3]) begin
      taskGrant = 5'h08;
    end else if (taskReq[4] && runMask[4]) begin
      taskGrant = 5'h10;
    end
  end

  // ----------------------------------------------------------------
  // Task watchdogs
  // ----------------------------------------------------------------
  wire [16:0] limits [0:4];
  wire [4:0]  wdOver;
  wire [16:0] safetyLimit;
  wire        safetyOver;
  reg         safeSeen_reg;
  genvar i;

  assign limits[0] = {1'b0, wdLimitTop};
  assign limits[1] = {1'b0, wdLimitSafe};
  assign limits[2] = {1'b0, wdLimitMain};
  assign limits[3] = {1'b0, wdLimitBg0};
  assign limits[4] = {1'b0, wdLimitBg1};

  generate
    for (i = 0; i < `TSEH_NTASK; i = i + 1) begin : gWdog
      // The count runs on while a busy task is preempted.
      tseh_wdog uWdog (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (tick),
        .active  (taskActive[i]),
        .armed   (runMask[i]),
        .limit   (limits[i]),
        .overrun (wdOver[i])
      );
    end
  endgenerate

  assign safetyLimit = {1'b0, wdLimitSafe} + {2'b00, wdLimitSafe[15:1]};

  // Safety watchdog spans protection task activity from the first start onward.
  tseh_wdog uSafetyWdog (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick),
    .active  (taskActive[`TSEH_TASK_SAFE]),
    .armed   (safeSeen_reg),
    .limit   (safetyLimit),
    .overrun (safetyOver)
  );

  always @(posedge sys_clk) begin
    if (rst) begin
      safeSeen_reg <= 1'b0;
    end else begin
      safeSeen_reg <= safeSeen_reg | safeRunning;
    end
  end

  // ----------------------------------------------------------------
  // Error classification
  // ----------------------------------------------------------------
  wire procWdErr;
  wire safeMismatch;
  wire fatalErr;

  assign procWdErr    = wdOver[0] | wdOver[2] | wdOver[3] | wdOver[4];
  assign safeMismatch = safeRunning && safeResultValid && !maintMode
                        && (safeResultA != safeResultB);
  assign fatalErr     = safetyOver | internalErr;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  reg [1:0] procSaved_reg;
  reg [1:0] procNext;
  reg [1:0] safeNext;
  reg [2:0] pacNext;

  always @* begin
    procNext = procState;
    safeNext = safeState;
    pacNext  = pacState;
    case (pacState)
      `TSEH_PAC_START: begin
        pacNext = `TSEH_PAC_NORMAL;
        if (autoStart && appValid) begin
          procNext = `TSEH_GRP_RUN;
          safeNext = `TSEH_GRP_RUN;
        end
      end
      `TSEH_PAC_NORMAL: begin
        if (fatalErr) begin
          pacNext  = `TSEH_PAC_ERROR;
          procNext = `TSEH_GRP_ERROR;
          safeNext = `TSEH_GRP_ERROR;
        end else if (powerDown) begin
          pacNext = `TSEH_PAC_WAIT;
        end else if (fwLoad) begin
          pacNext = `TSEH_PAC_FWLOAD;
        end else if (stopCmd) begin
          procNext = `TSEH_GRP_STOP;
          safeNext = `TSEH_GRP_STOP;
        end else if (runCmd && appValid) begin
          procNext = `TSEH_GRP_RUN;
          safeNext = `TSEH_GRP_RUN;
        end else begin
          if (procRunning && procWdErr) begin
            procNext = `TSEH_GRP_HALT;
          end
          if (safeRunning && (wdOver[1] || safeMismatch)) begin
            safeNext = `TSEH_GRP_HALT;
          end
        end
      end
      `TSEH_PAC_WAIT: begin
        if (!powerDown && powerBack) begin
          pacNext  = `TSEH_PAC_NORMAL;
          procNext = (procSaved_reg == `TSEH_GRP_HALT) ? `TSEH_GRP_STOP : procSaved_reg;
          safeNext = (autoStart && appValid) ? `TSEH_GRP_RUN : `TSEH_GRP_STOP;
        end
      end
      `TSEH_PAC_FWLOAD: begin
        procNext = `TSEH_GRP_STOP;
        safeNext = `TSEH_GRP_STOP;
        if (!fwLoad) begin
          pacNext = `TSEH_PAC_NORMAL;
        end
      end
      `TSEH_PAC_ERROR: begin
        pacNext = `TSEH_PAC_ERROR;
      end
      default: begin
        pacNext  = `TSEH_PAC_ERROR;
        procNext = `TSEH_GRP_ERROR;
        safeNext = `TSEH_GRP_ERROR;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pacState      <= `TSEH_PAC_START;
      procState     <= `TSEH_GRP_STOP;
      safeState     <= `TSEH_GRP_STOP;
      procSaved_reg <= `TSEH_GRP_STOP;
      saveData      <= 1'b0;
      safetyTrip    <= 1'b0;
      logValid      <= 1'b0;
      logCode       <= 2'h0;
    end else begin
      pacState   <= pacNext;
      procState  <= procNext;
      safeState  <= safeNext;
      saveData   <= (pacState == `TSEH_PAC_NORMAL) && (pacNext == `TSEH_PAC_WAIT);
      safetyTrip <= (pacNext == `TSEH_PAC_ERROR);
      if (pacNext == `TSEH_PAC_WAIT && pacState == `TSEH_PAC_NORMAL) begin
        procSaved_reg <= procState;
      end
      logValid <= (pacState == `TSEH_PAC_NORMAL) && !fatalErr && !powerDown && !fwLoad
                  && (stopCmd || (runCmd && appValid));
      logCode  <= stopCmd ? `TSEH_LOG_STOP : `TSEH_LOG_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Combined status message
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      statusMsg <= `TSEH_MSG_STOP;
    end else if (procNext == `TSEH_GRP_ERROR) begin
      statusMsg <= `TSEH_MSG_ERROR;
    end else if (procNext == `TSEH_GRP_HALT) begin
      statusMsg <= (safeNext == `TSEH_GRP_HALT) ? `TSEH_MSG_HALT
                                                : `TSEH_MSG_PROC_FRZ;
    end else if (safeNext == `TSEH_GRP_HALT) begin
      statusMsg <= `TSEH_MSG_SAFE_HALT;
    end else if (procNext == `TSEH_GRP_STOP && safeNext == `TSEH_GRP_STOP) begin
      statusMsg <= `TSEH_MSG_STOP;
    end else begin
      statusMsg <= `TSEH_MSG_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Per-task input, execution and output control
  // ----------------------------------------------------------------
  wire safeDown;

  // Inputs are sampled in run, stop and halt alike, but only while the controller is in the normal state.
  assign inSample        = (pacState == `TSEH_PAC_NORMAL) ? 5'h1F : 5'h00;
  assign execEn          = taskGrant & runMask;
  assign outUpdate       = runMask;
  assign outFallback     = ~runMask;
  assign safeDown        = (safeState == `TSEH_GRP_HALT) || (safeState == `TSEH_GRP_ERROR);
  assign safeOutHold     = safeDown && safeHoldSel;
  assign safeOutFallback = !safeRunning && !safeOutHold;
endmodule // tseh_core

// [design/tseh_wdog.v]
// Watchdog counter for one task, counting millisecond ticks while the task is busy.
`timescale 1ns/100ps
module tseh_wdog (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Control
  input  wire        tick,
  input  wire        active,
  input  wire        armed,
  input  wire [16:0] limit,
  // Result
  output wire        overrun
);
  reg  [16:0] count_reg;
  reg         fired_reg;
  wire        hit;

  assign hit     = active && armed && !fired_reg && (count_reg >= limit);
  assign overrun = hit;

  always @(posedge sys_clk) begin
    if (rst || !active || !armed) begin
      count_reg <= 17'h00000;
      fired_reg <= 1'b0;
    end else begin
      if (tick && (count_reg != 17'h1FFFF)) begin
        count_reg <= count_reg + 17'h00001;
      end
      if (hit) begin
        fired_reg <= 1'b1;
      end
    end
  end
endmodule // tseh_wdog

// [inc/tseh_regs.vh]
// Constants for the task state and detected error handler.
`ifndef TSEH_REGS_VH
`define TSEH_REGS_VH
// ----------------------------------------------------------------
// Task indices, in fixed priority order
// ----------------------------------------------------------------
`define TSEH_TASK_TOP       3'h0
`define TSEH_TASK_SAFE      3'h1
`define TSEH_TASK_MAIN      3'h2
`define TSEH_TASK_BG0       3'h3
`define TSEH_TASK_BG1       3'h4
`define TSEH_NTASK          5
// ----------------------------------------------------------------
// Group states
// ----------------------------------------------------------------
`define TSEH_GRP_STOP       2'h0
`define TSEH_GRP_RUN        2'h1
`define TSEH_GRP_HALT       2'h2
`define TSEH_GRP_ERROR      2'h3
// ----------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------
`define TSEH_PAC_NORMAL     3'h0
`define TSEH_PAC_WAIT       3'h1
`define TSEH_PAC_ERROR      3'h2
`define TSEH_PAC_FWLOAD     3'h3
`define TSEH_PAC_START      3'h4
// ----------------------------------------------------------------
// Combined status messages
// ----------------------------------------------------------------
`define TSEH_MSG_STOP       3'h0
`define TSEH_MSG_RUN        3'h1
`define TSEH_MSG_SAFE_HALT  3'h2
`define TSEH_MSG_PROC_FRZ   3'h3
`define TSEH_MSG_HALT       3'h4
`define TSEH_MSG_ERROR      3'h5
// ----------------------------------------------------------------
// Event log codes
// ----------------------------------------------------------------
`define TSEH_LOG_RUN        2'h1
`define TSEH_LOG_STOP       2'h2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSEH_CLK_PERIOD_NS  8
`define TSEH_TICK_TIME_MS   1
`define TSEH_TICK_CYCLES    (`TSEH_TICK_TIME_MS * 1000000 / `TSEH_CLK_PERIOD_NS)
`define TSEH_LIMIT_W        17
`endif

// [tb/tseh_core_bench.sv]
// Self-checking bench for the task state and detected error handler.
`timescale 1ns/100ps
`include "tseh_regs.vh"
module tseh_core_bench;
  reg         sys_clk = 1'h0;
  reg         rst = 1'h1;
  reg         runCmd = 1'h0, stopCmd = 1'h0, autoStart = 1'h0, appValid = 1'h1;
  reg         maintMode = 1'h0, safeHoldSel = 1'h0, safeResultValid = 1'h0, internalErr = 1'h0;
  reg         powerDownPin = 1'h0, powerOkPin = 1'h1, reserveFullPin = 1'h1;
  reg         fwLoadMainPin = 1'h0, fwLoadCoprocPin = 1'h0;
  reg  [15:0] wdLim = 16'h0002;
  reg  [4:0]  taskReq = 5'h00, taskActive = 5'h00;
  reg  [31:0] resA = 32'h0, resB = 32'h0;
  wire [4:0]  taskGrant, inSample, execEn, outUpdate, outFallback;
  wire        safeOutHold, safeOutFallback, safetyTrip, saveData, logValid;
  wire [1:0]  procState, safeState, logCode;
  wire [2:0]  pacState, statusMsg;
  integer     n_fail = 0;
  integer     n_checks = 0;
  always #4 sys_clk = ~sys_clk;
  tseh_core #(.TICK_CYCLES(4)) i_tseh_core (.sys_clk(sys_clk), .rst(rst), .runCmd(runCmd),
    .stopCmd(stopCmd), .autoStart(autoStart), .appValid(appValid), .maintMode(maintMode),
    .safeHoldSel(safeHoldSel), .wdLimitTop(wdLim), .wdLimitSafe(wdLim), .wdLimitMain(wdLim),
    .wdLimitBg0(wdLim), .wdLimitBg1(wdLim), .taskReq(taskReq), .taskActive(taskActive),
    .taskGrant(taskGrant), .safeResultValid(safeResultValid), .safeResultA(resA),
    .safeResultB(resB), .internalErr(internalErr), .powerDownPin(powerDownPin),
    .powerOkPin(powerOkPin), .reserveFullPin(reserveFullPin), .fwLoadMainPin(fwLoadMainPin),
    .fwLoadCoprocPin(fwLoadCoprocPin), .inSample(inSample), .execEn(execEn),
    .outUpdate(outUpdate), .outFallback(outFallback), .safeOutHold(safeOutHold),
    .safeOutFallback(safeOutFallback), .procState(procState), .safeState(safeState),
    .pacState(pacState), .statusMsg(statusMsg), .safetyTrip(safetyTrip),
    .saveData(saveData), .logValid(logValid), .logCode(logCode));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task step(input integer n);
    integer k;
    for (k = 0; k < n; k = k + 1) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task waitFor(input integer w, input [2:0] v);
    integer k;
    for (k = 0; k < 80 && (w == 0 ? {1'h0, procState} : w == 1 ? {1'h0, safeState}
         : pacState) !== v; k = k + 1) step(1);
  endtask
  task runPulse;
    begin
      runCmd = 1'h1;
      step(1);
      runCmd = 1'h0;
    end
  endtask
  task mismatch;
    begin
      resA = 32'h5;
      resB = 32'h6;
      safeResultValid = 1'h1;
      step(1);
      safeResultValid = 1'h0;
    end
  endtask
  task complete_run;
    begin
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_start_run;
    begin
      chk(statusMsg, `TSEH_MSG_STOP);
      chk(outFallback, 5'h1F);
      chk(inSample, 5'h1F);
      runPulse;
      chk(logValid, 1'h1);
      chk(logCode, `TSEH_LOG_RUN);
      chk(outUpdate, 5'h1F);
      taskReq = 5'h1F;
      step(1);
      chk(logValid, 1'h0);
      chk(taskGrant, 5'h01);
      chk(execEn, 5'h01);
      taskReq = 5'h1E;
      step(1);
      chk(taskGrant, 5'h02);
      taskReq = 5'h1C;
      step(1);
      chk(taskGrant, 5'h04);
      taskReq = 5'h00;
      stopCmd = 1'h1;
      runCmd = 1'h1;
      step(1);
      stopCmd = 1'h0;
      runCmd = 1'h0;
      chk(statusMsg, `TSEH_MSG_STOP);
      chk(logCode, `TSEH_LOG_STOP);
      chk(outFallback, 5'h1F);
      chk(pacState, `TSEH_PAC_NORMAL);
      appValid = 1'h0;
      runPulse;
      chk(procState, `TSEH_GRP_STOP);
      appValid = 1'h1;
      runPulse;
      chk(statusMsg, `TSEH_MSG_RUN);
    end
  endtask
  task t_process_freeze_message;
    begin
      taskActive = 5'h04;
      waitFor(0, `TSEH_GRP_HALT);
      taskActive = 5'h00;
      chk(safeState, `TSEH_GRP_RUN);
      chk(statusMsg, `TSEH_MSG_PROC_FRZ);
      chk(outUpdate, 5'h02);
      taskReq = 5'h1F;
      step(1);
      chk(taskGrant, 5'h02);
      taskReq = 5'h00;
      mismatch;
      chk(statusMsg, `TSEH_MSG_HALT);
      chk(procState, `TSEH_GRP_HALT);
      runPulse;
      chk(procState, `TSEH_GRP_RUN);
    end
  endtask
  task t_safe_halt;
    begin
      safeHoldSel = 1'h1;
      mismatch;
      chk(safeState, `TSEH_GRP_HALT);
      chk(statusMsg, `TSEH_MSG_SAFE_HALT);
      chk(safeOutHold, 1'h1);
      safeHoldSel = 1'h0;
      step(1);
      chk(safeOutFallback, 1'h1);
      runPulse;
      maintMode = 1'h1;
      mismatch;
      step(1);
      chk(safeState, `TSEH_GRP_RUN);
      maintMode = 1'h0;
      taskActive = 5'h02;
      taskReq = 5'h03;
      waitFor(1, `TSEH_GRP_HALT);
      taskActive = 5'h00;
      taskReq = 5'h00;
      chk(safeState, `TSEH_GRP_HALT);
      chk(procState, `TSEH_GRP_RUN);
      runPulse;
    end
  endtask
  task t_power_fw;
    begin
      powerDownPin = 1'h1;
      powerOkPin = 1'h0;
      waitFor(2, `TSEH_PAC_WAIT);
      chk(saveData, 1'h1);
      powerDownPin = 1'h0;
      step(8);
      chk(pacState, `TSEH_PAC_WAIT);
      powerOkPin = 1'h1;
      waitFor(2, `TSEH_PAC_NORMAL);
      chk(procState, `TSEH_GRP_RUN);
      chk(safeState, `TSEH_GRP_STOP);
      fwLoadCoprocPin = 1'h1;
      waitFor(2, `TSEH_PAC_FWLOAD);
      chk(pacState, `TSEH_PAC_FWLOAD);
      fwLoadCoprocPin = 1'h0;
      waitFor(2, `TSEH_PAC_NORMAL);
      fwLoadMainPin = 1'h1;
      step(4);
      chk(pacState, `TSEH_PAC_FWLOAD);
      fwLoadMainPin = 1'h0;
      waitFor(2, `TSEH_PAC_NORMAL);
    end
  endtask
  task t_fatal;
    begin
      runPulse;
      internalErr = 1'h1;
      step(1);
      internalErr = 1'h0;
      chk(safeState, `TSEH_GRP_ERROR);
      chk(safetyTrip, 1'h1);
      runPulse;
      step(1);
      chk(pacState, `TSEH_PAC_ERROR);
      rst = 1'h1;
      autoStart = 1'h1;
      step(2);
      rst = 1'h0;
      step(2);
      chk({procState, safeState}, {`TSEH_GRP_RUN, `TSEH_GRP_RUN});
      taskActive = 5'h02;
      waitFor(1, `TSEH_GRP_HALT);
      chk(pacState, `TSEH_PAC_NORMAL);
      step(6);
      taskActive = 5'h00;
      chk(pacState, `TSEH_PAC_ERROR);
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    complete_run;
  end
  initial begin
    step(16);
    rst = 1'h0;
    step(2);
    t_start_run;
    t_process_freeze_message;
    t_safe_halt;
    t_power_fw;
    t_fatal;
    complete_run;
  end
endmodule // tseh_core_bench
bind tseh_core tseh_core_props i_tseh_core_props (.sys_clk(sys_clk), .rst(rst),
  .stopCmd(stopCmd), .maintMode(maintMode), .safeHoldSel(safeHoldSel),
  .taskActive(taskActive), .safeResultValid(safeResultValid), .internalErr(internalErr),
  .inSample(inSample), .outUpdate(outUpdate), .safeOutHold(safeOutHold),
  .procState(procState), .safeState(safeState), .pacState(pacState),
  .statusMsg(statusMsg), .safetyTrip(safetyTrip), .saveData(saveData),
  .logValid(logValid), .logCode(logCode));

// [tb/tseh_core_props.sv]
// Concurrent checks on the task state and detected error handler ports.
`timescale 1ns/100ps
`include "tseh_regs.vh"
module tseh_core_props (
  // Clock and reset
  input wire       sys_clk,
  input wire       rst,
  // Inputs
  input wire       stopCmd,
  input wire       maintMode,
  input wire       safeHoldSel,
  input wire [4:0] taskActive,
  input wire       safeResultValid,
  input wire       internalErr,
  // Outputs
  input wire [4:0] inSample,
  input wire [4:0] outUpdate,
  input wire       safeOutHold,
  input wire [1:0] procState,
  input wire [1:0] safeState,
  input wire [2:0] pacState,
  input wire [2:0] statusMsg,
  input wire       safetyTrip,
  input wire       saveData,
  input wire       logValid,
  input wire [1:0] logCode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire nrm = pacState == `TSEH_PAC_NORMAL;
  wire pRun = nrm && procState == `TSEH_GRP_RUN;
  wire sRun = nrm && safeState == `TSEH_GRP_RUN;
  // Combined status expected from the two group states and the controller state.
  function [2:0] msgOf(input [1:0] p, input [1:0] s, input [2:0] c);
    if (c == `TSEH_PAC_ERROR) msgOf = `TSEH_MSG_ERROR;
    else if (p == `TSEH_GRP_HALT)
      msgOf = (s == `TSEH_GRP_HALT) ? `TSEH_MSG_HALT : `TSEH_MSG_PROC_FRZ;
    else if (s == `TSEH_GRP_HALT) msgOf = `TSEH_MSG_SAFE_HALT;
    else if (p == `TSEH_GRP_STOP && s == `TSEH_GRP_STOP) msgOf = `TSEH_MSG_STOP;
    else msgOf = `TSEH_MSG_RUN;
  endfunction
  a_process_freeze_message_alone: assert property ((procState == `TSEH_GRP_HALT &&
    $past(procState) != `TSEH_GRP_HALT) |-> safeState == $past(safeState))
    else $error("process halt changed protection state");
  a_safe_halt_alone: assert property ((safeState == `TSEH_GRP_HALT &&
    $past(safeState) != `TSEH_GRP_HALT) |-> procState == $past(procState))
    else $error("protection halt changed process state");
  a_input_sample: assert property (inSample == {5{nrm}})
    else $error("input sampling mask wrong");
  a_output_update: assert property (outUpdate == {pRun, pRun, pRun, sRun, pRun})
    else $error("output update mask wrong");
  a_maint_no_compare: assert property ((maintMode && safeResultValid && sRun &&
    !taskActive[1] && !internalErr && !stopCmd) |=> safeState != `TSEH_GRP_HALT)
    else $error("mismatch flagged in maintenance mode");
  a_run_log_states: assert property ((logValid && logCode == `TSEH_LOG_RUN) |->
    procState == `TSEH_GRP_RUN && safeState == `TSEH_GRP_RUN)
    else $error("run event without all tasks running");
  a_save_pulse: assert property ((pacState == `TSEH_PAC_WAIT &&
    $past(pacState) == `TSEH_PAC_NORMAL) |-> saveData ##1 !saveData)
    else $error("save pulse wrong on wait entry");
  a_error_sticky: assert property (pacState == `TSEH_PAC_ERROR |=>
    pacState == `TSEH_PAC_ERROR && safetyTrip && procState == `TSEH_GRP_ERROR)
    else $error("error state left without reset");
  a_fatal_entry: assert property ((internalErr && nrm) |=> pacState == `TSEH_PAC_ERROR &&
    procState == `TSEH_GRP_ERROR && safeState == `TSEH_GRP_ERROR)
    else $error("internal fault did not enter error");
  a_safe_out_hold: assert property (safeOutHold == (safeState[1] && safeHoldSel))
    else $error("safety hold output wrong");
  a_status_code: assert property (statusMsg == msgOf(procState, safeState, pacState))
    else $error("combined status wrong");
  c_process_freeze_message: cover property (procState == `TSEH_GRP_HALT);
  c_safe_halt: cover property (safeState == `TSEH_GRP_HALT);
  c_wait: cover property (pacState == `TSEH_PAC_WAIT);
  c_error: cover property (pacState == `TSEH_PAC_ERROR);
endmodule // tseh_core_props
